// ===== rtl/isl_pkg.sv
// Constants, field layouts and types shared by the internal serial link.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
package isl_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [15:0] IDX_CTRL = 16'hFFA0;
  localparam logic [15:0] IDX_STAT = 16'hFFA1;
  localparam logic [15:0] IDX_DATU = 16'hFFA2;
  localparam logic [15:0] IDX_DATL = 16'hFFA3;
  localparam logic [15:0] IDX_ISTAT = 16'hFFA4;
  localparam logic [15:0] IDX_IMASK = 16'hFFA5;
  localparam logic [15:0] IDX_STOP = 16'hFFFA;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h9C;
  localparam logic [7:0] STOP_RESET = 8'hFF;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  localparam int STAT_SOL_BIT = 6;
  localparam int STAT_ORER_BIT = 5;
  localparam int STAT_START_BIT = 0;
  localparam int STOP_CH_BIT = 7;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;

  localparam logic [1:0] MODE_SYNC8 = 2'h0;
  localparam logic [1:0] MODE_SYNC16 = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [2:0] DIV_WATCH = 3'h7;

  localparam logic [4:0] BITS_8 = 5'h08;
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [4:0] TAIL_PERIODS = 5'h02;

  typedef struct packed {
    logic [1:0] mode;
    logic tail_en;
    logic tail_type;
    logic clk_src;
    logic [2:0] div;
  } isl_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_TAIL = 3'b100
  } isl_state_t;

endpackage : isl_pkg

// ===== rtl/isl_link.sv
// Internal synchronous serial link: APB registers, prescaler, shifter, interrupt.
// Assumes every input is synchronous to mclk and watch_tick is a one-cycle pulse.
// How it works
// - Reset clears the control register to zero.
// - Control write during transfer stops it.
// - Mode field selects 8-bit, 16-bit, continuous.
// - Tail enable appends a tail after words.
// - Tail type bit picks hold or latch.
// - Clock source bit picks internal timing (prescaler or watch pulse) or pin.
// - Divider field picks the serial clock rate.
// - Each completed transfer sets the done flag; irq follows when its mask bit is set.
// - Data out and in, timed by clock.
// - Shift LSB first; in 16-bit mode upper feeds lower.
// - Start flag begins transfer outside continuous mode, reads busy.
// - Standby bit low resets channel registers.
`timescale 1ns/1ns
module isl_link
  import isl_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watch_tick,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin,
  output logic irq
);

  isl_ctrl_t ctrl_reg, ctrl_next;
  isl_state_t state_reg, state_next;
  logic [4:0] bitcnt_reg, bitcnt_next;
  logic [7:0] datu_reg, datu_next;
  logic [7:0] datl_reg, datl_next;
  logic [7:0] stop_reg;
  logic [1:0] imask_reg;
  logic [1:0] istat_reg, istat_next;
  logic [9:0] ps_reg;
  logic wcnt_reg;
  logic sck_reg, sck_next;
  logic ext_prev_reg;
  logic so_reg, so_next;
  logic orer_reg, orer_next;
  logic done_ev;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic sck_oe_reg;

  // Selects the half-period strobe of the prescaler for a divider code.
  function automatic logic half_tick(input logic [9:0] ps, input logic [2:0] sel);
    case (sel)
      3'h0: half_tick = &ps[8:0];
      3'h1: half_tick = &ps[6:0];
      3'h2: half_tick = &ps[4:0];
      3'h3: half_tick = &ps[3:0];
      3'h4: half_tick = &ps[2:0];
      3'h5: half_tick = &ps[1:0];
      3'h6: half_tick = ps[0];
      default: half_tick = 1'b0;
    endcase
  endfunction : half_tick

  // APB decode. The access phase always takes two cycles so that every answer is registered.
  wire [15:0] reg_idx = paddr[ADDR_W-1:2];
  wire apb_fire = psel & penable & pready_reg;
  wire wr = apb_fire & pwrite & pstrb[0];
  wire rd = apb_fire & ~pwrite;
  wire hit_ctrl = reg_idx == IDX_CTRL;
  wire hit_stat = reg_idx == IDX_STAT;
  wire hit_datu = reg_idx == IDX_DATU;
  wire hit_datl = reg_idx == IDX_DATL;
  wire hit_istat = reg_idx == IDX_ISTAT;
  wire hit_imask = reg_idx == IDX_IMASK;
  wire hit_stop = reg_idx == IDX_STOP;
  wire hit_any = hit_ctrl | hit_stat | hit_datu | hit_datl | hit_istat | hit_imask | hit_stop;

  wire standby = ~stop_reg[STOP_CH_BIT];
  wire idle = state_reg == ST_IDLE;
  wire busy = ~idle;
  wire tail_busy = state_reg == ST_TAIL;
  wire cont_mode = ctrl_reg.mode == MODE_CONT;
  wire is16 = ctrl_reg.mode == MODE_SYNC16;
  wire [4:0] data_bits = is16 ? BITS_16 : BITS_8;
  wire [4:0] cnt_inc = bitcnt_reg + 5'h01;

  wire w_ctrl = wr & hit_ctrl & ~standby;
  wire w_stat = wr & hit_stat & ~standby;
  wire w_datu = wr & hit_datu & ~standby & idle;
  wire w_datl = wr & hit_datl & ~standby & idle;
  wire rd_istat = rd & hit_istat;
  wire start_req = w_stat & pwdata[STAT_START_BIT] & idle & ~cont_mode;

  // Serial clock timing: internal strobes from the prescaler or watch pulse, or pin edges.
  wire watch_half = watch_tick & wcnt_reg;
  wire int_tick = ~ctrl_reg.clk_src &
                  ((ctrl_reg.div == DIV_WATCH) ? watch_half : half_tick(ps_reg, ctrl_reg.div));
  wire ext_fall = ext_prev_reg & ~serial_clock_pin_i;
  wire ext_rise = ~ext_prev_reg & serial_clock_pin_i;
  wire shift_fall = busy & (ctrl_reg.clk_src ? ext_fall : (int_tick & sck_reg));
  wire shift_rise = busy & (ctrl_reg.clk_src ? ext_rise : (int_tick & ~sck_reg));
  wire ovr_ev = ctrl_reg.clk_src & idle & ext_fall & ~cont_mode & ~standby;

  wire [7:0] stat_rd = {1'b1, so_reg, orer_reg, 3'b111, tail_busy, busy};
  wire [7:0] rd_value = hit_ctrl ? ctrl_reg :
                        hit_stat ? stat_rd :
                        hit_datu ? datu_reg :
                        hit_datl ? datl_reg :
                        hit_istat ? {6'h00, istat_reg} :
                        hit_imask ? {6'h00, imask_reg} :
                        hit_stop ? stop_reg : 8'h00;

  // Serial clock level. In the synchronous modes it only toggles while a word or its tail is moving.
  always_comb begin
    if (ctrl_reg.clk_src || standby) begin
      sck_next = 1'b1;
    end else if (cont_mode && !w_ctrl) begin
      sck_next = int_tick ? ~sck_reg : sck_reg;
    end else if (busy && !w_ctrl) begin
      sck_next = int_tick ? ~sck_reg : sck_reg;
    end else begin
      sck_next = 1'b1;
    end
  end

  // Transfer sequencer and shifter.
  always_comb begin
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    datu_next = datu_reg;
    datl_next = datl_reg;
    so_next = so_reg;
    done_ev = 1'b0;
    ctrl_next = w_ctrl ? isl_ctrl_t'(pwdata[7:0]) : ctrl_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_req) begin
          state_next = ST_DATA;
          bitcnt_next = 5'h00;
        end
      end
      ST_DATA: begin
        if (shift_fall) begin
          so_next = datl_reg[0];
        end
        if (shift_rise) begin
          datl_next = {is16 ? datu_reg[0] : serial_data_in_pin, datl_reg[7:1]};
          if (is16) begin
            datu_next = {serial_data_in_pin, datu_reg[7:1]};
          end
          bitcnt_next = cnt_inc;
          if (cnt_inc == data_bits) begin
            bitcnt_next = 5'h00;
            if (ctrl_reg.tail_en) begin
              state_next = ST_TAIL;
            end else begin
              state_next = ST_IDLE;
              done_ev = 1'b1;
            end
          end
        end
      end
      ST_TAIL: begin
        if (shift_fall) begin
          so_next = ctrl_reg.tail_type;
        end
        if (shift_rise) begin
          bitcnt_next = cnt_inc;
          if (cnt_inc == TAIL_PERIODS) begin
            bitcnt_next = 5'h00;
            state_next = ST_IDLE;
            done_ev = 1'b1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (w_datu) begin
      datu_next = pwdata[7:0];
    end
    if (w_datl) begin
      datl_next = pwdata[7:0];
    end
    if (w_stat && idle) begin
      so_next = pwdata[STAT_SOL_BIT];
    end
    if (w_ctrl) begin
      state_next = ST_IDLE;
      bitcnt_next = 5'h00;
      done_ev = 1'b0;
    end
    if (standby) begin
      ctrl_next = isl_ctrl_t'(CTRL_RESET);
      state_next = ST_IDLE;
      bitcnt_next = 5'h00;
      datu_next = DATA_RESET;
      datl_next = DATA_RESET;
      so_next = STAT_RESET[STAT_SOL_BIT];
      done_ev = 1'b0;
    end
  end

  // Hardware sets win over a software clear in the same cycle.
  always_comb begin
    orer_next = orer_reg;
    if (w_stat && !pwdata[STAT_ORER_BIT]) begin
      orer_next = 1'b0;
    end
    if (ovr_ev) begin
      orer_next = 1'b1;
    end
    if (standby) begin
      orer_next = STAT_RESET[STAT_ORER_BIT];
    end
    istat_next = rd_istat ? 2'h0 : istat_reg;
    istat_next[IRQ_DONE_BIT] = istat_next[IRQ_DONE_BIT] | done_ev;
    istat_next[IRQ_OVR_BIT] = istat_next[IRQ_OVR_BIT] | ovr_ev;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= isl_ctrl_t'(CTRL_RESET);
      state_reg <= ST_IDLE;
      bitcnt_reg <= 5'h00;
      datu_reg <= DATA_RESET;
      datl_reg <= DATA_RESET;
      so_reg <= STAT_RESET[STAT_SOL_BIT];
      orer_reg <= STAT_RESET[STAT_ORER_BIT];
    end else begin
      ctrl_reg <= ctrl_next;
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      datu_reg <= datu_next;
      datl_reg <= datl_next;
      so_reg <= so_next;
      orer_reg <= orer_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ps_reg <= 10'h000;
      wcnt_reg <= 1'b0;
      sck_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
      sck_oe_reg <= 1'b1;
    end else begin
      ps_reg <= standby ? 10'h000 : ps_reg + 10'h001;
      wcnt_reg <= watch_tick ? ~wcnt_reg : wcnt_reg;
      sck_reg <= sck_next;
      ext_prev_reg <= serial_clock_pin_i;
      sck_oe_reg <= ~ctrl_next.clk_src;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stop_reg <= STOP_RESET;
      imask_reg <= IRQ_RESET;
      istat_reg <= IRQ_RESET;
      irq_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      stop_reg <= (wr && hit_stop) ? pwdata[7:0] : stop_reg;
      imask_reg <= (wr && hit_imask) ? pwdata[1:0] : imask_reg;
      istat_reg <= istat_next;
      irq_reg <= |(istat_next & imask_reg);
      prdata_reg <= (psel && penable && !pwrite) ? {24'h000000, rd_value} : 32'h00000000;
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~hit_any;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign serial_clock_pin_o = sck_reg;
  assign serial_clock_pin_oe = sck_oe_reg;
  assign serial_data_out_pin = so_reg;
  assign irq = irq_reg;

  property p_ctrl_reset;
    @(posedge mclk) rst |=> ctrl_reg == isl_ctrl_t'(CTRL_RESET) && state_reg == ST_IDLE;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not cleared by reset");
  property p_abort;
    @(posedge mclk) disable iff (rst) (busy && w_ctrl) |=> idle && !istat_reg[IRQ_DONE_BIT] ||
      idle && $past(istat_reg[IRQ_DONE_BIT]);
  endproperty
  a_abort: assert property (p_abort) else $error("control write did not stop transfer");
  property p_cont_clock;
    @(posedge mclk) disable iff (rst) (cont_mode && int_tick && !w_ctrl && !standby)
      |=> sck_reg != $past(sck_reg);
  endproperty
  a_cont_clock: assert property (p_cont_clock) else $error("continuous clock stalled");
  property p_no_tail;
    @(posedge mclk) disable iff (rst || standby)
      (state_reg == ST_DATA && shift_rise && cnt_inc == data_bits && !w_ctrl)
      |=> (state_reg == (ctrl_reg.tail_en ? ST_TAIL : ST_IDLE));
  endproperty
  a_no_tail: assert property (p_no_tail) else $error("tail choice wrong after word");
  property p_tail_level;
    @(posedge mclk) disable iff (rst || standby) (tail_busy && shift_fall && !w_ctrl)
      |=> serial_data_out_pin == ctrl_reg.tail_type;
  endproperty
  a_tail_level: assert property (p_tail_level) else $error("tail level wrong");
  property p_clk_dir;
    @(posedge mclk) disable iff (rst) ##1 serial_clock_pin_oe == !$past(ctrl_next.clk_src);
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock pin direction wrong");
  property p_div4;
    @(posedge mclk) disable iff (rst || w_ctrl || standby)
      (int_tick && ctrl_reg.div == 3'h6 && !ctrl_reg.clk_src) |=> !int_tick ##1 int_tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four strobe wrong");
  property p_done_irq;
    @(posedge mclk) disable iff (rst) done_ev |=> istat_reg[IRQ_DONE_BIT] ##1
      (irq == imask_reg[IRQ_DONE_BIT] || irq);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("completion not flagged");
  property p_lsb_first;
    @(posedge mclk) disable iff (rst || standby)
      (state_reg == ST_DATA && shift_fall && !w_stat) |=> serial_data_out_pin == $past(datl_reg[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("output bit not LSB of shifter");
  property p_start;
    @(posedge mclk) disable iff (rst) start_req |=> state_reg == ST_DATA && stat_rd[0];
  endproperty
  a_start: assert property (p_start) else $error("start flag did not begin transfer");
  property p_standby;
    @(posedge mclk) disable iff (rst) standby |=> ctrl_reg == isl_ctrl_t'(CTRL_RESET) &&
      idle && datl_reg == DATA_RESET && !orer_reg;
  endproperty
  a_standby: assert property (p_standby) else $error("standby did not clear channel");
  property p_idle_clock;
    @(posedge mclk) disable iff (rst) (idle && !cont_mode && $past(idle)) |-> sck_reg;
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("clock moved while idle");
  property p_count_bound;
    @(posedge mclk) disable iff (rst) (state_reg == ST_DATA) |-> bitcnt_reg < data_bits;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("bit count overran word");
  c_done8: cover property (@(posedge mclk) done_ev && !is16 && !ctrl_reg.tail_en);
  c_done16: cover property (@(posedge mclk) done_ev && is16);
  c_tail: cover property (@(posedge mclk) tail_busy && shift_rise);
  c_overrun: cover property (@(posedge mclk) ovr_ev);
endmodule : isl_link

// ===== dv/isl_decoder_model.sv
// Behavioural far-side decoder for the internal serial link.
// Assumes the serial clock idles high and is sampled on mclk.
`timescale 1ns/1ns
module isl_decoder_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic sck,
  input wire logic so,
  input wire logic [4:0] nbits,
  input wire logic [15:0] tx,
  output logic si,
  output logic [15:0] rx,
  output logic [4:0] count
);
  logic sck_prev;
  always @(posedge mclk) begin
    sck_prev <= sck;
    if (rst || clear) begin
      count <= 5'h00;
      rx <= 16'h0000;
      si <= 1'b0;
    end else begin
      if (!sck_prev && sck) begin
        rx <= {so, rx[15:1]};
        count <= count + 5'h01;
      end
      // After a frame the line toggles so a stale bit cannot pass.
      if (count >= nbits) si <= ~si;
      else if (sck_prev && !sck) si <= tx[count[3:0]];
    end
  end
endmodule : isl_decoder_model

// ===== dv/isl_link_tb.sv
// Self-checking bench for the internal serial link.
// Assumes the decoder model on the serial side and a 10 MHz mclk.
`timescale 1ns/1ns
module isl_link_tb;
  import isl_pkg::*;
  logic mclk, rst, psel, penable, pwrite, watch_tick, sck_in, si, so, sck_o, sck_oe;
  logic irq, pready, pslverr, err, m_clear;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] m_tx, m_rx;
  logic [4:0] m_nbits, m_count;
  int mismatches, checks_done, wcnt;
  isl_link dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watch_tick(watch_tick), .serial_clock_pin_i(sck_in),
    .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe), .serial_data_in_pin(si),
    .serial_data_out_pin(so), .irq(irq));
  isl_decoder_model partner (.mclk(mclk), .rst(rst), .clear(m_clear), .sck(sck_o),
    .so(so), .nbits(m_nbits), .tx(m_tx), .si(si), .rx(m_rx), .count(m_count));
  always @(posedge mclk) begin
    wcnt <= (wcnt == 3) ? 0 : wcnt + 1;
    watch_tick <= (wcnt == 3);
  end
  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask : rdc
  task automatic run_xfer(input logic [7:0] ctrl, input logic [4:0] nb, input logic [15:0] tx);
    int n;
    m_nbits <= nb;
    m_tx <= tx;
    m_clear <= 1'b1;
    @(posedge mclk);
    m_clear <= 1'b0;
    apb(1'b1, IDX_DATU, tx[15:8] ^ 8'hFF);
    apb(1'b1, IDX_DATL, tx[7:0] ^ 8'hFF);
    apb(1'b1, IDX_CTRL, ctrl);
    apb(1'b1, IDX_STAT, 8'h01);
    apb(1'b0, IDX_STAT, 8'h00);
    chk({31'h0, rd[STAT_START_BIT]}, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, IDX_STAT, 8'h00);
    chk({31'h0, rd[STAT_START_BIT]}, 32'h0);
    rdc(IDX_ISTAT, 8'h01);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
  endtask : run_xfer
  task automatic t_reset;
    rdc(IDX_CTRL, CTRL_RESET);
    rdc(IDX_STAT, STAT_RESET);
    rdc(IDX_STOP, STOP_RESET);
    apb(1'b0, 16'h0123, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk({30'h0, sck_oe, sck_o}, 32'h3);
    apb(1'b1, IDX_IMASK, 8'h01);
  endtask : t_reset
  task automatic t_xfer8;
    run_xfer(8'h06, 5'd8, 16'h003C);
    chk({24'h0, m_rx[15:8]}, 32'hC3);
    chk({27'h0, m_count}, 32'd8);
    rdc(IDX_DATL, 8'h3C);
  endtask : t_xfer8
  task automatic t_xfer16;
    run_xfer(8'h45, 5'd16, 16'hC31E);
    chk({16'h0, m_rx}, 32'h3CE1);
    chk({27'h0, m_count}, 32'd16);
    rdc(IDX_DATL, 8'h1E);
    rdc(IDX_DATU, 8'hC3);
  endtask : t_xfer16
  task automatic t_tail;
    for (int t = 0; t < 2; t++) begin
      run_xfer({3'b001, t[0], 4'h6}, 5'd8, 16'h005A);
      chk({27'h0, m_count}, {27'h0, BITS_8 + TAIL_PERIODS});
      chk({31'h0, m_rx[15]}, {31'h0, t[0]});
    end
  endtask : t_tail
  task automatic t_abort;
    apb(1'b1, IDX_CTRL, 8'h00);
    apb(1'b1, IDX_STAT, 8'h01);
    apb(1'b1, IDX_CTRL, 8'h00);
    apb(1'b0, IDX_STAT, 8'h00);
    chk({31'h0, rd[STAT_START_BIT]}, 32'h0);
    repeat (40) @(posedge mclk);
    rdc(IDX_ISTAT, 8'h00);
    chk({31'h0, sck_o}, 32'h1);
  endtask : t_abort
  task automatic t_divider;
    int exp_p[8] = '{1024, 256, 64, 32, 16, 8, 4, 16};
    int n, t0, p;
    logic prev;
    for (int c = 0; c < 8; c++) begin
      // Continuous mode leaves the data pins to software and unused here.
      apb(1'b1, IDX_CTRL, {5'b10000, c[2:0]});
      prev = sck_o;
      n = 0;
      t0 = -1;
      p = 0;
      while (n < 3000 && p == 0) begin
        @(posedge mclk);
        n++;
        if (prev === 1'b1 && sck_o === 1'b0) begin
          if (t0 < 0) t0 = n;
          else p = n - t0;
        end
        prev = sck_o;
      end
      chk(p, exp_p[c]);
    end
    apb(1'b1, IDX_CTRL, 8'h00);
  endtask : t_divider
  task automatic t_ext_clock;
    apb(1'b1, IDX_CTRL, 8'h08);
    chk({31'h0, sck_oe}, 32'h0);
    sck_in <= 1'b0;
    repeat (4) @(posedge mclk);
    sck_in <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc(IDX_ISTAT, 8'h02);
    apb(1'b1, IDX_STAT, 8'h00);
    apb(1'b1, IDX_CTRL, 8'h00);
    chk({31'h0, sck_oe}, 32'h1);
  endtask : t_ext_clock
  task automatic t_standby;
    apb(1'b1, IDX_CTRL, 8'h45);
    rdc(IDX_CTRL, 8'h45);
    apb(1'b1, IDX_STOP, 8'h7F);
    rdc(IDX_CTRL, 8'h00);
    rdc(IDX_STAT, STAT_RESET);
    rdc(IDX_DATU, DATA_RESET);
    rdc(IDX_STOP, 8'h7F);
    apb(1'b1, IDX_STOP, 8'hFF);
  endtask : t_standby
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #2000000;
    mismatches++;
    complete_run();
  end
  initial begin
    {rst, psel, penable, pwrite, m_clear} = 5'b10000;
    {paddr, pwdata, pstrb, sck_in, m_tx, m_nbits} = {18'h0, 32'h0, 4'hF, 1'b1, 16'h0, 5'd8};
    {mismatches, checks_done} = {32'd0, 32'd0};
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_xfer8();
    t_xfer16();
    t_tail();
    t_abort();
    t_divider();
    t_ext_clock();
    t_standby();
    complete_run();
  end
endmodule : isl_link_tb
